// ===== bss_params.svh
// constants for the backup supply switchover block
`ifndef BSS_PARAMS_SVH
`define BSS_PARAMS_SVH
`define BSS_SYNC_STAGES     2
`define BSS_STABLE_SAMPLES  2'h2
`define BSS_SEL_MAIN        1'b0
`define BSS_SEL_BACKUP      1'b1
`define BSS_DSS_RESET       1'b0
`define BSS_TPL_RESET       1'b1
`define BSS_SEAL_RESET      1'b1
`endif

// ===== bss_pkg.sv
// types for the backup supply switchover block
package bss_pkg;
  // comparator results from the analog supply monitors
  typedef struct packed {
    logic main_below_backup_hys; // main < backup - hysteresis
    logic main_below_trip;       // main < trip threshold
    logic main_above_backup_hys; // main > backup + hysteresis
    logic main_above_trip_hys;   // main > trip + trip hysteresis
    logic main_below_backup;     // main < backup, direct switch compare
  } bss_cmp_t;
  // software register strobes and data, from the serial register file
  typedef struct packed {
    logic dss_wr;        // write strobe for control register bit
    logic dss_data;      // direct_switch_select value
    logic status_wr;     // write strobe for status register
    logic seal_request;  // seal_request bit written
    logic tpl_clear;     // status write data clears total_power_loss_flag
    logic clock_wr;      // any byte written to clock registers
  } bss_sw_t;
  typedef enum logic [1:0] {
    BSS_SEALED = 2'b00,
    BSS_MAIN   = 2'b01,
    BSS_BACKUP = 2'b10
  } bss_state_t;
endpackage

// ===== bss_filter.sv
// synchroniser and three-sample stability filter for comparator levels
`timescale 1ns/1ps
`default_nettype none
`include "bss_params.svh"
module bss_filter #(
  parameter int WIDTH = 5
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_b,
  // raw and filtered levels
  input  wire logic [WIDTH-1:0] raw,
  output var  logic [WIDTH-1:0] stable
);
  logic [WIDTH-1:0] sync1;
  logic [WIDTH-1:0] sync2;
  logic [WIDTH-1:0] last;
  logic [1:0]       agree;

  // refuse a zero-width filter at elaboration
  if (WIDTH < 1) begin : g_width_check
    $error("bss_filter width must be positive");
  end

  // two-flop synchroniser; sync1 feeds sync2 only
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= raw;
      sync2 <= sync1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      last   <= '0;
      agree  <= 2'h0;
      stable <= '0;
    end else begin
      last <= sync2;
      if (sync2 != last) begin
        agree <= 2'h1;
      end else if (agree != `BSS_STABLE_SAMPLES) begin
        agree <= agree + 2'h1;
      end else begin
        stable <= sync2;
      end
    end
  end

  // output moves only after equal samples
  filter_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    $changed(stable) |-> $past(sync2) == $past(sync2, 2) && $past(sync2, 2) == $past(sync2, 3))
    else $error("filter output moved on an unstable input");
endmodule
`default_nettype wire

// ===== bss_top.sv
// backup supply switchover control for the battery-backed clock
`timescale 1ns/1ps
`default_nettype none
`include "bss_params.svh"
module bss_top (
  // clock and reset (reset marks power-up after total supply loss)
  input  wire logic             core_clk,
  input  wire logic             rst_b,
  // analog comparators, asynchronous
  input  wire bss_pkg::bss_cmp_t cmp,
  // main supply present, asynchronous
  input  wire logic             main_good,
  // register file strobes, same clock
  input  wire bss_pkg::bss_sw_t sw,
  // supply selection and enables
  output var  logic             backup_select,
  output var  logic             backup_switch_en,
  output var  logic             trip_monitor_en,
  output var  logic             serial_enable,
  output var  logic             timekeep_run,
  output var  logic             other_io_enable,
  // register-visible bits
  output var  logic             direct_switch_select,
  output var  logic             total_power_loss_flag,
  output var  logic             sealed
);
  import bss_pkg::*;

  bss_cmp_t   cmp_s;
  logic       main_s;
  bss_state_t state;
  bss_state_t next_state;
  logic       go_backup;
  logic       go_main;
  logic       clock_written;
  logic       seal_request_wait;

  ////////////////////////////////////////////////////////////////////
  // register strobe decode, shared by the state machine and the flags
  function automatic logic seal_request_req(input bss_sw_t s);
    return s.status_wr & s.seal_request;
  endfunction

  function automatic logic flag_clear_req(input bss_sw_t s);
    return s.status_wr & s.tpl_clear;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // comparator conditioning
  // sync and filter
  bss_filter #(.WIDTH($bits(bss_cmp_t) + 1)) u_filter (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .raw      ({cmp, main_good}),
    .stable   ({cmp_s, main_s})
  );

  ////////////////////////////////////////////////////////////////////
  // switchover decisions
  always_comb begin
    if (direct_switch_select) begin
      go_backup = cmp_s.main_below_backup;
      go_main   = cmp_s.main_above_backup_hys;
    end else begin
      go_backup = cmp_s.main_below_backup_hys & cmp_s.main_below_trip;
      go_main   = cmp_s.main_above_backup_hys | cmp_s.main_above_trip_hys;
    end
  end

  // state transitions
  always_comb begin
    next_state = state;
    case (state)
      // wait for main before any backup draw
      BSS_SEALED: begin
        // seal_request needs main to drop first
        if (main_s && !seal_request_wait) next_state = BSS_MAIN;
      end
      BSS_MAIN: begin
        if (seal_request_req(sw)) next_state = BSS_SEALED;
        else if (go_backup) next_state = BSS_BACKUP;
      end
      BSS_BACKUP: begin
        if (go_main) next_state = BSS_MAIN;
      end
      default: next_state = BSS_SEALED;
    endcase
  end

  // sealed until main first seen
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) state <= BSS_SEALED;
    else        state <= next_state;
  end

  // seal_request waits for power-up
  // a seal_request written under main would otherwise unseal on the next edge
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b)                                   seal_request_wait <= 1'b0;
    else if (state == BSS_MAIN && seal_request_req(sw)) seal_request_wait <= 1'b1;
    else if (!main_s)                             seal_request_wait <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////
  // register bits
  // software sets mode bit
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b)        direct_switch_select <= `BSS_DSS_RESET;
    else if (sw.dss_wr) direct_switch_select <= sw.dss_data;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    // set at power-up after total loss
    if (!rst_b) total_power_loss_flag <= `BSS_TPL_RESET;
    else if (flag_clear_req(sw)) total_power_loss_flag <= 1'b0;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b)           clock_written <= 1'b0;
    else if (sw.clock_wr) clock_written <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////
  // registered outputs
  // supply and seal outputs follow next_state so they never lag the state flop
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      backup_select    <= `BSS_SEL_MAIN;
      backup_switch_en <= 1'b0;
      trip_monitor_en  <= 1'b0;
      serial_enable    <= 1'b0;
      timekeep_run     <= 1'b0;
      other_io_enable  <= 1'b1;
      sealed           <= `BSS_SEAL_RESET;
    end else begin
      backup_select    <= (next_state == BSS_BACKUP);
      backup_switch_en <= (next_state != BSS_SEALED);
      // monitor powered down in low power
      trip_monitor_en  <= !direct_switch_select;
      serial_enable    <= (next_state != BSS_BACKUP);
      timekeep_run     <= clock_written | sw.clock_wr;
      other_io_enable  <= 1'b1;
      sealed           <= (next_state == BSS_SEALED);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // assertions
  serial_off_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    backup_select |-> !serial_enable) else $error("serial port on during backup");
  sealed_nobk_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    sealed |-> !backup_select && !backup_switch_en) else $error("backup used while sealed");
  normal_sw_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(backup_select) && !$past(direct_switch_select) |->
      $past(cmp_s.main_below_trip) && $past(cmp_s.main_below_backup_hys))
    else $error("normal switch without both conditions");
  return_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    backup_select && !direct_switch_select && cmp_s.main_above_trip_hys |=> !backup_select)
    else $error("no return to main");
  lowpwr_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    state == BSS_MAIN && direct_switch_select && cmp_s.main_below_backup
      && !(sw.status_wr && sw.seal_request) |=> backup_select)
    else $error("low power switch missed");
  monitor_off_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    direct_switch_select |=> !trip_monitor_en) else $error("trip monitor on in low power");
  seal_request_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    state == BSS_MAIN && sw.status_wr && sw.seal_request |=> sealed)
    else $error("seal request ignored");
  tpl_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    !(sw.status_wr && sw.tpl_clear) && total_power_loss_flag |=> total_power_loss_flag)
    else $error("loss flag dropped without clear");
  frozen_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    !clock_written && !sw.clock_wr |=> !timekeep_run) else $error("counters ran early");
  dss_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    sw.dss_wr |=> direct_switch_select == $past(sw.dss_data)) else $error("mode bit lost");
  io_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    other_io_enable) else $error("other pins disabled");
  // seal_request, switchover, timekeeping and flag guards
  seal_request_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    sealed && seal_request_wait |=> sealed) else $error("seal_request left before power-up");
  trip_needed_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    state == BSS_MAIN && !direct_switch_select && !cmp_s.main_below_trip |=> !backup_select)
    else $error("normal switch above trip");
  lp_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    backup_select && direct_switch_select && !cmp_s.main_above_backup_hys |=> backup_select)
    else $error("low power switched back inside hysteresis");
  run_start_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(timekeep_run) |-> $past(sw.clock_wr))
    else $error("counters started without clock write");
  keep_run_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    timekeep_run |=> timekeep_run) else $error("timekeeping stopped");
  tpl_clear_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    $fell(total_power_loss_flag) |-> $past(sw.status_wr) && $past(sw.tpl_clear))
    else $error("loss flag cleared without status write");

  cov_backup_c: cover property (@(posedge core_clk) disable iff (!rst_b) $rose(backup_select));
  cov_return_c: cover property (@(posedge core_clk) disable iff (!rst_b) $fell(backup_select));
  cov_seal_request_c: cover property (@(posedge core_clk) disable iff (!rst_b) $rose(sealed));
  cov_lowpwr_c: cover property (@(posedge core_clk) disable iff (!rst_b)
    direct_switch_select && $rose(backup_select));
  cov_sealwait_c: cover property (@(posedge core_clk) disable iff (!rst_b)
    sealed && seal_request_wait ##1 !seal_request_wait);
endmodule
`default_nettype wire

// ===== bss_rail_model.sv
// comparator model for the main and backup rails
`timescale 1ns/1ps
`default_nettype none
module bss_rail_model #(
  parameter int TRIP_MV  = 2600,
  parameter int HYS_MV   = 50,
  parameter int TRHYS_MV = 30,
  parameter int GOOD_MV  = 1800
) (
  // rail levels in millivolts
  input  wire integer            main_mv,
  input  wire integer            bat_mv,
  // comparator results
  output var  bss_pkg::bss_cmp_t cmp,
  output var  logic              main_good
);
  import bss_pkg::*;
  ////////////////////////////////////////////////////////////
  // threshold compares
  // levels move at once, as a real comparator would
  always_comb begin
    cmp.main_below_backup_hys = main_mv < bat_mv - HYS_MV;
    cmp.main_below_trip       = main_mv < TRIP_MV;
    cmp.main_above_backup_hys = main_mv > bat_mv + HYS_MV;
    cmp.main_above_trip_hys   = main_mv > TRIP_MV + TRHYS_MV;
    cmp.main_below_backup     = main_mv < bat_mv;
  end
  // crude presence detect, a fixed level
  assign main_good = main_mv >= GOOD_MV;
endmodule
`default_nettype wire

// ===== tb.sv
// self-checking bench for the backup supply switchover block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import bss_pkg::*;
  logic     core_clk, rst_b, main_good;
  bss_cmp_t cmp;
  bss_sw_t  sw;
  logic     backup_select, backup_switch_en, trip_monitor_en, serial_enable;
  logic     timekeep_run, other_io_enable, direct_switch_select;
  logic     total_power_loss_flag, sealed;
  integer   main_mv, bat_mv;
  int       errors, n_checks;
  // far side rails
  bss_rail_model i_rail (.main_mv(main_mv), .bat_mv(bat_mv), .cmp(cmp),
    .main_good(main_good));
  bss_top i_dut (.core_clk(core_clk), .rst_b(rst_b), .cmp(cmp),
    .main_good(main_good), .sw(sw), .backup_select(backup_select),
    .backup_switch_en(backup_switch_en), .trip_monitor_en(trip_monitor_en),
    .serial_enable(serial_enable), .timekeep_run(timekeep_run),
    .other_io_enable(other_io_enable), .direct_switch_select(direct_switch_select),
    .total_power_loss_flag(total_power_loss_flag), .sealed(sealed));
  ////////////////////////////////////////////////////////////
  // clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic rail(input integer m, input integer b);
    @(posedge core_clk);
    main_mv <= m;
    bat_mv <= b;
  endtask
  // waits are bounded; the filter needs about six edges
  task automatic wait_sel(input logic exp);
    int i;
    for (i = 0; i < 30 && backup_select !== exp; i++) @(posedge core_clk);
    #1;
    if (i == 30) begin
      errors++;
      summarize();
    end
  endtask
  task automatic strobe(input bss_sw_t v);
    @(posedge core_clk);
    sw <= v;
    @(posedge core_clk);
    sw <= '0;
    #1;
  endtask
  ////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_sealed();
    rail(1000, 3300);
    idle(12);
    chk(backup_select, 1'b0);
    chk(backup_switch_en, 1'b0);
    rail(3300, 3300);
    idle(12);
    chk(sealed, 1'b0);
    chk(serial_enable, 1'b1);
  endtask
  task automatic t_normal();
    rail(3000, 3300);
    idle(12);
    chk(backup_select, 1'b0);
    rail(2500, 3300);
    wait_sel(1'b1);
    chk(serial_enable, 1'b0);
    chk({other_io_enable, timekeep_run}, 2'h3);
    rail(2700, 3300);
    wait_sel(1'b0);
    chk(serial_enable, 1'b1);
    rail(1900, 2000);
    wait_sel(1'b1);
    rail(2100, 2000);
    wait_sel(1'b0);
    chk(backup_select, 1'b0);
    // below trip but inside the backup hysteresis: stay on main
    rail(2500, 2530);
    idle(12);
    chk(backup_select, 1'b0);
  endtask
  // a one-cycle dip must not switch supplies
  task automatic t_glitch();
    logic seen_bk;
    seen_bk = 1'b0;
    rail(2500, 3300);
    rail(3300, 3300);
    // watch every cycle; a passed glitch would return to main by itself
    repeat (12) begin
      @(posedge core_clk);
      #1;
      seen_bk = seen_bk | backup_select;
    end
    chk(seen_bk, 1'b0);
  endtask
  task automatic t_lowpower();
    strobe(6'h30);
    idle(1);
    chk({direct_switch_select, trip_monitor_en}, 2'h2);
    rail(3280, 3300);
    wait_sel(1'b1);
    chk(backup_select, 1'b1);
    // inside the band; only trip plus hysteresis would pull a normal device back
    rail(3330, 3300);
    idle(12);
    chk(backup_select, 1'b1);
    rail(3400, 3300);
    wait_sel(1'b0);
    strobe(6'h20);
    idle(1);
    chk({direct_switch_select, trip_monitor_en}, 2'h1);
  endtask
  task automatic t_seal_request();
    strobe(6'h0c);
    chk({sealed, backup_switch_en}, 2'h2);
    // main still present: must stay sealed until the next power-up
    idle(12);
    chk(sealed, 1'b1);
    rail(1000, 3300);
    idle(12);
    chk(backup_select, 1'b0);
    rail(3300, 3300);
    idle(12);
    chk(sealed, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst_b = 1'b0;
    sw = '0;
    main_mv = 0;
    bat_mv = 3300;
    errors = 0;
    n_checks = 0;
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    idle(1);
    chk({sealed, total_power_loss_flag, other_io_enable}, 3'h7);
    chk({direct_switch_select, backup_select, timekeep_run}, 3'h0);
    t_sealed();
    chk(timekeep_run, 1'b0);
    strobe(6'h01);
    chk(timekeep_run, 1'b1);
    t_normal();
    t_glitch();
    t_lowpower();
    strobe(6'h0a);
    chk(total_power_loss_flag, 1'b0);
    t_seal_request();
    // second power-up after total loss, mode bit set beforehand
    strobe(6'h30);
    @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    idle(1);
    chk({total_power_loss_flag, sealed, timekeep_run}, 3'h6);
    chk({direct_switch_select, backup_select}, 2'h0);
    summarize();
  end
endmodule
`default_nettype wire
